/* uhp_pkg.sv */
// package for the usb host pipe control register block
package uhp_pkg;
  localparam int NPIPE = 7;
  localparam logic [7:0] A_FLAGS   = 8'h00;
  localparam logic [7:0] A_ENABLES = 8'h01;
  localparam logic [7:0] A_ADDR    = 8'h02;
  localparam logic [7:0] A_FNUMH   = 8'h03;
  localparam logic [7:0] A_FNUML   = 8'h04;
  localparam logic [7:0] A_FLEN    = 8'h05;
  localparam logic [7:0] A_PSEL    = 8'h06;
  localparam logic [7:0] A_PRST    = 8'h07;
  localparam logic [7:0] A_PCTL    = 8'h08;
  localparam logic [7:0] A_CFG0    = 8'h09;
  localparam logic [7:0] A_CFG1    = 8'h0A;
  localparam logic [7:0] A_CFG2    = 8'h0B;
  localparam logic [7:0] A_STAT    = 8'h0C;
  localparam logic [7:0] A_IN_REQUEST_COUNT    = 8'h0D;
  localparam int B_UPRSM = 4;
  localparam int B_DNRSM = 3;
  localparam int B_BRST  = 2;
  localparam int B_DET   = 1;
  localparam int B_ATT   = 0;
  localparam int B_FRZ   = 6;
  localparam int B_INM   = 5;
  localparam int B_TGL   = 3;
  localparam int B_PEN   = 0;
  localparam int B_MEMORY_CLAIM_BIT = 1;
  localparam int B_CONFIG_VALID_STATUS = 7;
  localparam logic [7:0] M_FLAGS = 8'h1F;
  localparam logic [7:0] M_EN    = 8'h7F;
  localparam logic [7:0] RST_VAL = 8'h00;
  localparam logic [7:0] PCTL_RST = 8'h40;
  localparam logic [1:0] T_CTRL = 2'h0;
  localparam logic [1:0] T_INT  = 2'h3;
  localparam logic [1:0] K_IN   = 2'h1;
  localparam logic [2:0] S_MAX_OTHER = 3'h3;
  typedef enum logic [1:0] {T_CONTROL, T_ISO, T_BULK, T_INTR} uhp_type_e;
  typedef struct packed {
    logic       attach;
    logic       detach;
    logic       reset_done;
    logic       up_resume;
    logic       dn_resume_done;
  } uhp_ev_s;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } uhp_bus_s;
  typedef struct packed {
    logic       stall;
    logic       error;
    logic       in_done;
    logic       toggle_clear;
  } uhp_pev_s;
endpackage : uhp_pkg

/* uhp_regs.sv */
// host pipe control register file and pipe control state
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
module uhp_regs (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire uhp_pkg::uhp_bus_s bus,
  output logic [7:0]             rdata,
  input  wire uhp_pkg::uhp_ev_s  ev,
  input  wire logic              bus_reset_drive,
  input  wire logic [7:0]        sent_frame_length,
  input  wire logic              sof_tick,
  input  wire uhp_pkg::uhp_pev_s pev,
  output logic                   host_irq,
  output logic [6:0]             target_device_addr,
  output logic [2:0]             pipe_select_index,
  output logic [6:0]             pipe_reset_pulse,
  output logic                   toggle_restart,
  output logic [6:0]             pipe_active,
  output logic [6:0]             pipe_request_en,
  output logic [1:0]             sel_transfer_type,
  output logic [1:0]             sel_token_kind,
  output logic [3:0]             sel_target_endpoint,
  output logic [8:0]             sel_buffer_bytes,
  output logic                   sel_two_banks,
  output logic [7:0]             sel_poll_period
);
  localparam int N = uhp_pkg::NPIPE;
  logic [7:0]  flags_q, en_q, addr_q, fnh_q, fnl_q, psel_q, prst_q, rdata_q;
  logic [7:0]  pctl_q [N];
  logic [7:0]  cfg0_q [N];
  logic [7:0]  cfg1_q [N];
  logic [7:0]  cfg2_q [N];
  logic [7:0]  in_request_count_q [N];
  logic [6:0]  config_valid_status;
  logic [4:0]  ev_v;
  logic [2:0]  p;

  function automatic logic wr_at(input uhp_pkg::uhp_bus_s b, input logic [7:0] a);
    wr_at = b.wr && (b.addr == a);
  endfunction : wr_at

  // control pipe must be single bank; size codes above 64 only on pipe 1
  function automatic logic cfg_valid(input logic [7:0] c0, input logic [7:0] c1,
                                     input int idx);
    cfg_valid = c1[uhp_pkg::B_MEMORY_CLAIM_BIT] && !c1[3]
                && !(c0[7:6] == uhp_pkg::T_CTRL && c1[3:2] != 2'h0)
                && (c1[6:4] <= uhp_pkg::S_MAX_OTHER ||
                    (idx == 1 && c1[6:4] <= 3'h5));
  endfunction : cfg_valid

  assign p    = psel_q[2:0];
  assign ev_v = {ev.up_resume, ev.dn_resume_done, ev.reset_done, ev.detach, ev.attach};

  // set wins over clear; software can only clear flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= uhp_pkg::RST_VAL;
    end else begin
      flags_q <= ((wr_at(bus, uhp_pkg::A_FLAGS) ? (flags_q & bus.wdata) : flags_q)
                  | {3'h0, ev_v}) & uhp_pkg::M_FLAGS;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q   <= uhp_pkg::RST_VAL;
      psel_q <= uhp_pkg::RST_VAL;
      prst_q <= uhp_pkg::RST_VAL;
    end else begin
      if (wr_at(bus, uhp_pkg::A_ENABLES)) en_q <= bus.wdata & uhp_pkg::M_EN;
      if (wr_at(bus, uhp_pkg::A_PSEL)) psel_q <= {5'h0, bus.wdata[2:0]};
      if (wr_at(bus, uhp_pkg::A_PRST)) prst_q <= {1'b0, bus.wdata[6:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= uhp_pkg::RST_VAL;
    end else if (bus_reset_drive) begin
      addr_q <= uhp_pkg::RST_VAL;
    end else if (wr_at(bus, uhp_pkg::A_ADDR)) begin
      addr_q <= {1'b0, bus.wdata[6:0]};
    end
  end

  // frame counter advances on each start-of-frame, software writes win
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fnh_q <= uhp_pkg::RST_VAL;
      fnl_q <= uhp_pkg::RST_VAL;
    end else if (wr_at(bus, uhp_pkg::A_FNUMH)) begin
      fnh_q <= {5'h0, bus.wdata[2:0]};
    end else if (wr_at(bus, uhp_pkg::A_FNUML)) begin
      fnl_q <= bus.wdata;
    end else if (sof_tick) begin
      {fnh_q[2:0], fnl_q} <= 11'({fnh_q[2:0], fnl_q} + 11'h001);
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_pipe
    logic rst_ev, en_rise, sel_w;
    assign sel_w   = (p == 3'(i));
    assign rst_ev  = prst_q[i] && wr_at(bus, uhp_pkg::A_PRST) && !bus.wdata[i];
    assign en_rise = sel_w && wr_at(bus, uhp_pkg::A_PCTL) && bus.wdata[uhp_pkg::B_PEN]
                     && !pctl_q[i][uhp_pkg::B_PEN];
    assign config_valid_status[i] = pctl_q[i][uhp_pkg::B_PEN] && cfg_valid(cfg0_q[i], cfg1_q[i], i);

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        pctl_q[i] <= uhp_pkg::PCTL_RST;
      end else begin
        if (sel_w && wr_at(bus, uhp_pkg::A_PCTL)) begin
          pctl_q[i] <= {1'b0, bus.wdata[6:5], 1'b0,
                        bus.wdata[3] | pctl_q[i][3], 2'h0, bus.wdata[0]};
        end
        if (sel_w && pctl_q[i][uhp_pkg::B_TGL])
          pctl_q[i][uhp_pkg::B_TGL] <= 1'b0;
        if (rst_ev || en_rise || !config_valid_status[i] ||
            (sel_w && (pev.stall || pev.error ||
             (pev.in_done && !pctl_q[i][uhp_pkg::B_INM] && in_request_count_q[i] == 8'h00))))
          pctl_q[i][uhp_pkg::B_FRZ] <= 1'b1;
      end
    end

    // clearing the enable wipes configuration; pipe reset leaves it alone
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        cfg0_q[i] <= uhp_pkg::RST_VAL;
        cfg1_q[i] <= uhp_pkg::RST_VAL;
        cfg2_q[i] <= uhp_pkg::RST_VAL;
        in_request_count_q[i] <= uhp_pkg::RST_VAL;
      end else if (!pctl_q[i][uhp_pkg::B_PEN] || bus_reset_drive) begin
        cfg0_q[i] <= uhp_pkg::RST_VAL;
        cfg1_q[i] <= uhp_pkg::RST_VAL;
        cfg2_q[i] <= uhp_pkg::RST_VAL;
        in_request_count_q[i] <= uhp_pkg::RST_VAL;
      end else if (sel_w) begin
        if (wr_at(bus, uhp_pkg::A_CFG0)) cfg0_q[i] <= bus.wdata;
        if (wr_at(bus, uhp_pkg::A_CFG1)) cfg1_q[i] <= {1'b0, bus.wdata[6:2], bus.wdata[1], 1'b0};
        if (wr_at(bus, uhp_pkg::A_CFG2)) cfg2_q[i] <= bus.wdata;
        if (wr_at(bus, uhp_pkg::A_IN_REQUEST_COUNT)) in_request_count_q[i] <= bus.wdata;
        else if (pev.in_done && in_request_count_q[i] != 8'h00)
          in_request_count_q[i] <= 8'(in_request_count_q[i] - 8'h01);
      end
    end

    assign pipe_reset_pulse[i] = rst_ev;
    assign pipe_active[i]      = config_valid_status[i];
    assign pipe_request_en[i]  = config_valid_status[i] && !pctl_q[i][uhp_pkg::B_FRZ];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= uhp_pkg::RST_VAL;
    end else if (bus.rd) begin
      case (bus.addr)
        uhp_pkg::A_FLAGS:   rdata_q <= flags_q;
        uhp_pkg::A_ENABLES: rdata_q <= en_q;
        uhp_pkg::A_ADDR:    rdata_q <= addr_q;
        uhp_pkg::A_FNUMH:   rdata_q <= fnh_q;
        uhp_pkg::A_FNUML:   rdata_q <= fnl_q;
        uhp_pkg::A_FLEN:    rdata_q <= sent_frame_length;
        uhp_pkg::A_PSEL:    rdata_q <= psel_q;
        uhp_pkg::A_PRST:    rdata_q <= prst_q;
        uhp_pkg::A_PCTL:    rdata_q <= (p < 3'(N)) ? pctl_q[p] : 8'h00;
        uhp_pkg::A_CFG0:    rdata_q <= (p < 3'(N)) ? cfg0_q[p] : 8'h00;
        uhp_pkg::A_CFG1:    rdata_q <= (p < 3'(N)) ? cfg1_q[p] : 8'h00;
        uhp_pkg::A_CFG2:    rdata_q <= (p < 3'(N)) ? cfg2_q[p] : 8'h00;
        uhp_pkg::A_STAT:    rdata_q <= (p < 3'(N)) ? {config_valid_status[p], 7'h00} : 8'h00;
        uhp_pkg::A_IN_REQUEST_COUNT:    rdata_q <= (p < 3'(N)) ? in_request_count_q[p] : 8'h00;
        default:            rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  logic [7:0] sel_c0, sel_c1;
  assign sel_c0 = (p < 3'(N)) ? cfg0_q[p] : 8'h00;
  assign sel_c1 = (p < 3'(N)) ? cfg1_q[p] : 8'h00;

  assign rdata               = rdata_q;
  assign host_irq            = |(flags_q & en_q);
  assign target_device_addr  = addr_q[6:0];
  assign pipe_select_index   = p;
  assign toggle_restart      = (p < 3'(N)) ? pctl_q[p][uhp_pkg::B_TGL] : 1'b0;
  assign sel_transfer_type   = sel_c0[7:6];
  assign sel_token_kind      = sel_c0[5:4];
  assign sel_target_endpoint = sel_c0[3:0];
  assign sel_buffer_bytes    = 9'(9'h008 << sel_c1[6:4]);
  assign sel_two_banks       = sel_c1[2];
  assign sel_poll_period     = (sel_c0[7:6] == uhp_pkg::T_INT && p < 3'(N))
                               ? cfg2_q[p] : 8'h00;
endmodule : uhp_regs

/* uhp_regs_props.sv */
// port assertions for the host pipe register block
`timescale 1ns/10ps
module uhp_regs_props (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire uhp_pkg::uhp_bus_s bus,
  input wire logic [7:0]        rdata,
  input wire logic              bus_reset_drive,
  input wire logic [7:0]        sent_frame_length,
  input wire uhp_pkg::uhp_pev_s pev,
  input wire logic              host_irq,
  input wire logic [6:0]        target_device_addr,
  input wire logic [2:0]        pipe_select_index,
  input wire logic [6:0]        pipe_active,
  input wire logic [6:0]        pipe_request_en,
  input wire logic [1:0]        sel_transfer_type,
  input wire logic              sel_two_banks,
  input wire logic [7:0]        sel_poll_period
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_addr_bus_rst: assert property (bus_reset_drive |=> target_device_addr == 7'h00)
    else $error("address kept after bus reset");
  chk_addr_write: assert property (bus.wr && bus.addr == uhp_pkg::A_ADDR && !bus_reset_drive
    |=> target_device_addr == $past(bus.wdata[6:0]))
    else $error("address write lost");
  chk_rdata_idle: assert property (!bus.rd |=> rdata == 8'h00)
    else $error("read data outside read slot");
  chk_flen_read: assert property (bus.rd && bus.addr == uhp_pkg::A_FLEN
    |=> rdata == $past(sent_frame_length))
    else $error("frame length read wrong");
  chk_poll_gate: assert property (sel_transfer_type != uhp_pkg::T_INT |-> sel_poll_period == 8'h00)
    else $error("poll period on non interrupt pipe");
  chk_req_active: assert property ((pipe_request_en & ~pipe_active) == 7'h00)
    else $error("requests on unconfigured pipe");
  chk_stall_freeze: assert property (pev.stall |=> !pipe_request_en[$past(pipe_select_index)])
    else $error("stall did not freeze");
  chk_irq_hold: assert property (host_irq && !bus.wr |=> host_irq)
    else $error("flag dropped without software");
  chk_ctrl_bank: assert property (sel_two_banks && sel_transfer_type == uhp_pkg::T_CTRL
    |-> !pipe_active[pipe_select_index])
    else $error("control pipe valid with two banks");
endmodule : uhp_regs_props

/* uhp_dev_model.sv */
// attached device model: bus events and handshakes as one-cycle pulses
`timescale 1ns/10ps
module uhp_dev_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        go,
  input  wire logic [3:0]  sel,
  output uhp_pkg::uhp_ev_s  ev,
  output uhp_pkg::uhp_pev_s pev
);
  logic [8:0] ev_q;
  // registered so events never land on the edge the bench changes go
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ev_q <= '0;
    else ev_q <= go ? (9'h001 << sel) : '0;
  end
  assign ev  = ev_q[4:0];
  assign pev = ev_q[8:5];
endmodule : uhp_dev_model

/* uhp_regs_test.sv */
// self-checking bench for the host pipe register block
`timescale 1ns/10ps
module uhp_regs_test;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  uhp_pkg::uhp_bus_s bus = '0;
  logic [2:0]        strb = 3'h0;
  logic [3:0]        sel = 4'h0;
  logic [7:0]        flen = 8'hA5;
  uhp_pkg::uhp_ev_s  ev;
  uhp_pkg::uhp_pev_s pev;
  logic [7:0]        rdata, poll;
  logic              irq, tgl, two;
  logic [6:0]        addr, rpl, act, req;
  logic [2:0]        psel;
  logic [1:0]        ttyp, tok;
  logic [3:0]        ep;
  logic [8:0]        bytes;
  int                errors = 0;
  int                checked = 0;
  int                fb[5] = '{3, 4, 2, 1, 0};
  logic [6:0]        rst_seen = 7'h00;
  // pipe reset pulse lasts only the write cycle, so keep a sticky copy
  always @(posedge clk) rst_seen <= rst_seen | rpl;
  always #5 clk = ~clk;
  uhp_dev_model u_dev (.clk, .rst_b, .go(strb[2]), .sel, .ev, .pev);
  uhp_regs u_dut (.clk, .rst_b, .bus, .rdata, .ev, .bus_reset_drive(strb[0]),
    .sent_frame_length(flen), .sof_tick(strb[1]), .pev, .host_irq(irq),
    .target_device_addr(addr), .pipe_select_index(psel), .pipe_reset_pulse(rpl),
    .toggle_restart(tgl), .pipe_active(act), .pipe_request_en(req),
    .sel_transfer_type(ttyp), .sel_token_kind(tok), .sel_target_endpoint(ep),
    .sel_buffer_bytes(bytes), .sel_two_banks(two), .sel_poll_period(poll));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      errors++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd
  // bit 0 bus reset, bit 1 frame tick, bit 2 device event chosen by s
  task automatic hit(input int b, input logic [3:0] s);
    @(posedge clk);
    strb <= 3'h1 << b;
    sel <= s;
    @(posedge clk);
    strb <= 3'h0;
    @(posedge clk);
    #1;
  endtask : hit
  task automatic cfg(input logic [7:0] p, c0, c1, c2);
    wr(uhp_pkg::A_PSEL, p);
    wr(uhp_pkg::A_PCTL, 8'h01);
    wr(uhp_pkg::A_CFG0, c0);
    wr(uhp_pkg::A_CFG1, c1);
    wr(uhp_pkg::A_CFG2, c2);
  endtask : cfg
  task automatic test_done;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  initial begin
    #200000;
    errors++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd(uhp_pkg::A_ADDR, 8'h00);
    rd(uhp_pkg::A_CFG2, 8'h00);
    rd(8'hFF, 8'h00);
    wr(uhp_pkg::A_ENABLES, 8'hBF);
    rd(uhp_pkg::A_ENABLES, 8'h3F);
    for (int k = 0; k < 5; k++) begin
      wr(uhp_pkg::A_ENABLES, 8'h00);
      hit(2, 4'(k));
      chk(irq, 1'b0);
      wr(uhp_pkg::A_ENABLES, 8'h01 << fb[k]);
      chk(irq, 1'b1);
      wr(uhp_pkg::A_FLAGS, 8'hFF);
      rd(uhp_pkg::A_FLAGS, 8'h01 << fb[k]);
      wr(uhp_pkg::A_FLAGS, 8'h00);
      rd(uhp_pkg::A_FLAGS, 8'h00);
    end
    wr(uhp_pkg::A_ADDR, 8'hFF);
    rd(uhp_pkg::A_ADDR, 8'h7F);
    hit(0, 4'h0);
    chk(addr, 7'h00);
    wr(uhp_pkg::A_FNUMH, 8'h07);
    wr(uhp_pkg::A_FNUML, 8'hFF);
    hit(1, 4'h0);
    rd(uhp_pkg::A_FNUML, 8'h00);
    rd(uhp_pkg::A_FNUMH, 8'h00);
    rd(uhp_pkg::A_FLEN, 8'hA5);
    cfg(8'h01, 8'h95, 8'h56, 8'h20);
    chk({ttyp, tok, ep}, 8'h95);
    chk(bytes, 9'h100);
    chk(two, 1'b1);
    chk(poll, 8'h00);
    chk(act, 7'h02);
    chk(psel, 3'h1);
    rd(uhp_pkg::A_STAT, 8'h80);
    rd(uhp_pkg::A_PCTL, 8'h41);
    wr(uhp_pkg::A_PCTL, 8'h01);
    chk(req, 7'h02);
    hit(2, 4'h8);
    chk(req, 7'h00);
    wr(uhp_pkg::A_PCTL, 8'h09);
    chk(tgl, 1'b1);
    rd(uhp_pkg::A_PCTL, 8'h01);
    wr(uhp_pkg::A_PRST, 8'h02);
    chk(rst_seen, 7'h00);
    wr(uhp_pkg::A_PRST, 8'h00);
    chk(rst_seen, 7'h02);
    rd(uhp_pkg::A_PCTL, 8'h41);
    rd(uhp_pkg::A_CFG0, 8'h95);
    wr(uhp_pkg::A_PCTL, 8'h00);
    chk(act, 7'h00);
    cfg(8'h02, 8'h00, 8'h06, 8'h00);
    chk(act, 7'h00);
    rd(uhp_pkg::A_STAT, 8'h00);
    cfg(8'h03, 8'hD5, 8'h02, 8'h20);
    chk(poll, 8'h20);
    chk(act, 7'h08);
    wr(uhp_pkg::A_IN_REQUEST_COUNT, 8'h01);
    wr(uhp_pkg::A_PCTL, 8'h01);
    chk(req, 7'h08);
    hit(2, 4'h6);
    chk(req, 7'h08);
    rd(uhp_pkg::A_IN_REQUEST_COUNT, 8'h00);
    hit(2, 4'h6);
    chk(req, 7'h00);
    wr(uhp_pkg::A_PCTL, 8'h21);
    hit(2, 4'h6);
    chk(req, 7'h08);
    hit(2, 4'h7);
    chk(req, 7'h00);
    wr(uhp_pkg::A_CFG1, 8'h00);
    chk(act, 7'h00);
    test_done();
  end
endmodule : uhp_regs_test
bind uhp_regs uhp_regs_props u_chk (.clk, .rst_b, .bus, .rdata, .bus_reset_drive,
  .sent_frame_length, .pev, .host_irq, .target_device_addr, .pipe_select_index,
  .pipe_active, .pipe_request_en, .sel_transfer_type, .sel_two_banks, .sel_poll_period);
